// [mio_map.svh]
// Offsets, field positions, reset values and timing counts of the decoder
`ifndef MIO_MAP_SVH
`define MIO_MAP_SVH
// I/O window offsets
`define MIO_WIN_BITS 5
`define MIO_OFS_UART_B_BIT 3
`define MIO_OFS_SPI 5'h10
`define MIO_OFS_CSEL 5'h11
`define MIO_OFS_PAR 5'h18
`define MIO_IO_FRONT_PANEL 8'hff
`define MIO_IO_BASES 8
// Memory map
`define MIO_BLOCKS 8
`define MIO_BLOCK_LSB 13
`define MIO_ROM_AW 15
// Reset values
`define MIO_CSEL_RST 1'b1
`define MIO_PAR_OUT_RST 8'h00
`define MIO_UNUSED_RD 8'hff
// Timing
`define MIO_CLK_HZ 200000000
`define MIO_SPI_HZ 2000000
`define MIO_SPI_BITS 8
`endif

// [mio_pkg.sv]
// Types shared by the memory and I/O decoder
package mio_pkg;
    typedef enum logic [0:0] {
        MIO_SPI_IDLE = 1'b0,
        MIO_SPI_SHIFT = 1'b1
    } mio_spi_state_t;
    typedef enum logic [1:0] {
        MIO_TGT_EXT = 2'b00,
        MIO_TGT_RAM = 2'b01,
        MIO_TGT_ROM = 2'b10
    } mio_target_t;
endpackage

// [mio_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module mio_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("FIFO depth must be a power of two of at least 2");
    end
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule

// [mio_decoder.sv]
// Memory, shadow ROM and I/O window decoder with SPI and parallel ports
`timescale 1ns/1ps
`include "mio_map.svh"
module mio_decoder #(
    parameter int FIFO_DEPTH = 8,
    parameter int CLK_HZ = `MIO_CLK_HZ,
    parameter int SPI_HZ = `MIO_SPI_HZ
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Bus side address, data and status
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_data_out,
    input wire logic status_mem_read,
    input wire logic status_io_in,
    input wire logic status_io_out,
    input wire logic data_in_strobe,
    input wire logic write_strobe_n,
    // Bus drive
    output logic [7:0] bus_data_in,
    output logic bus_data_in_oe,
    output logic bus_wait,
    output logic hold_req,
    output logic mem_write,
    output logic mem_write_oe,
    output logic run_out,
    output logic run_oe,
    // Buffer steering
    output logic dout_buf_to_bus,
    output logic dout_buf_en,
    output logic din_buf_to_cpu,
    output logic din_buf_en,
    // ROM chip
    output logic [14:0] rom_addr,
    input wire logic [7:0] rom_data,
    // Serial ports
    input wire logic [7:0] uart_rdata,
    output logic uart_a_sel,
    output logic uart_b_sel,
    output logic [2:0] uart_reg,
    output logic uart_rd,
    output logic uart_wr,
    output logic [7:0] uart_wdata,
    // SD card
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso,
    output logic card_select_n,
    // Parallel ports
    input wire logic [7:0] parallel_in,
    output logic [7:0] parallel_out,
    output logic parallel_strobe,
    // Jumpers
    input wire logic [7:0] ram_block_jumpers,
    input wire logic [7:0] rom_block_jumpers,
    input wire logic [7:0] io_base_jumper,
    input wire logic shadow_kill_source_jumper,
    input wire logic master_slave_jumper,
    input wire logic machine_type_jumper,
    input wire logic external_memory_jumper,
    input wire logic standalone_write_jumper
);
    localparam int HALF = CLK_HZ / (2 * SPI_HZ);
    localparam int SYNC_W = 83;
    // Reset to idle pin levels; write strobe is active low, so no false edge
    localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'(32);
    if (HALF < 1 || HALF > 255) begin : g_bad_rate
        $error("SPI rate not reachable from system clock");
    end
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser: three stages, a bit moves once stages two and three agree
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [SYNC_W-1:0] flt;
    wire [SYNC_W-1:0] pins = {bus_addr, bus_data_out, rom_data, uart_rdata, parallel_in,
        ram_block_jumpers, rom_block_jumpers, io_base_jumper, spi_miso, status_mem_read,
        status_io_in, status_io_out, data_in_strobe, write_strobe_n,
        shadow_kill_source_jumper, master_slave_jumper, machine_type_jumper,
        external_memory_jumper, standalone_write_jumper};
    wire [SYNC_W-1:0] agree = ~(sync2 ^ sync3);
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1 <= SYNC_IDLE;
            sync2 <= SYNC_IDLE;
            sync3 <= SYNC_IDLE;
            flt <= SYNC_IDLE;
        end
        else
        begin
            sync1 <= pins;
            sync2 <= sync1;
            sync3 <= sync2;
            flt <= (agree & sync3) | (~agree & flt);
        end
    end
    // Unpack filtered pins; all decode works on these bus-side copies
    wire [15:0] a = flt[82:67];
    wire [7:0] wdata = flt[66:59];
    wire [7:0] rom_q = flt[58:51];
    wire [7:0] uart_q = flt[50:43];
    wire [7:0] par_in = flt[42:35];
    wire [7:0] ram_j = flt[34:27];
    wire [7:0] rom_j = flt[26:19];
    wire [7:0] io_j = flt[18:11];
    wire miso = flt[10];
    wire st_memr = flt[9];
    wire st_inp = flt[8];
    wire st_out = flt[7];
    wire dbin = flt[6];
    wire wr_n = flt[5];
    wire kill_src_par = flt[4];
    wire slave = flt[3];
    wire panel_shows_bus = flt[2];
    wire ext_mem = flt[1];
    wire standalone = flt[0];
    ////////////////////////////////////////////////////////////////////////////
    // Cycle classification
    wire io_cycle = st_inp || st_out;
    wire read_act = dbin && (st_memr || st_inp);
    wire mem_rd = dbin && st_memr;
    wire io_rd = dbin && st_inp;
    wire wr_act = !wr_n;
    wire mem_wr = wr_act && !st_out;
    wire io_wr = wr_act && st_out;
    logic wr_prev;
    wire wr_edge = wr_act && !wr_prev;
    ////////////////////////////////////////////////////////////////////////////
    // Memory decode and shadow ROM
    logic kill_cs;
    logic [7:0] ram [0:65535];
    logic [7:0] ram_q;
    logic [7:0] par_q;
    wire [2:0] blk = a[15:13];
    wire blk_ram = ram_j[blk];
    wire blk_rom = rom_j[blk];
    wire killed = kill_src_par ? par_q[0] : kill_cs;
    wire rom_reads = blk_rom && !(blk_ram && killed);
    mio_pkg::mio_target_t rd_tgt;
    assign rd_tgt = rom_reads ? mio_pkg::MIO_TGT_ROM
        : (blk_ram ? mio_pkg::MIO_TGT_RAM : mio_pkg::MIO_TGT_EXT);
    wire ram_takes_wr = blk_ram || blk_rom;
    wire mem_hit = (rd_tgt != mio_pkg::MIO_TGT_EXT);
    always_ff @(posedge clk_sys)
    begin
        ram_q <= ram[a];
        if (wr_edge && mem_wr && !io_cycle && ram_takes_wr)
            ram[a] <= wdata;
    end
    ////////////////////////////////////////////////////////////////////////////
    // I/O window decode
    logic [2:0] base_idx;
    logic base_any;
    always_comb
    begin
        base_idx = 3'h0;
        base_any = 1'b0;
        for (int i = `MIO_IO_BASES - 1; i >= 0; i--)
        begin
            if (io_j[i])
            begin
                base_idx = 3'(i);
                base_any = 1'b1;
            end
        end
    end
    wire [4:0] ofs = a[4:0];
    wire io_hit = io_cycle && base_any && (a[7:5] == base_idx)
        && (a[7:0] != `MIO_IO_FRONT_PANEL);
    wire hit_uart = io_hit && (ofs[4] == 1'b0);
    wire hit_uart_b = hit_uart && ofs[`MIO_OFS_UART_B_BIT];
    wire hit_spi = io_hit && (ofs == `MIO_OFS_SPI);
    wire hit_csel = io_hit && (ofs == `MIO_OFS_CSEL);
    wire hit_par = io_hit && (ofs == `MIO_OFS_PAR);
    wire onboard = io_cycle ? io_hit : mem_hit;
    ////////////////////////////////////////////////////////////////////////////
    // I/O register writes
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic spi_pop;
    logic [7:0] spi_rx;
    wire wr_spi = wr_edge && io_wr && hit_spi;
    wire wr_csel = wr_edge && io_wr && hit_csel;
    wire wr_par = wr_edge && io_wr && hit_par;
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_prev <= 1'b0;
            card_select_n <= `MIO_CSEL_RST;
            kill_cs <= 1'b0;
            par_q <= `MIO_PAR_OUT_RST;
            parallel_strobe <= 1'b0;
        end
        else
        begin
            wr_prev <= wr_act;
            parallel_strobe <= wr_par;
            if (wr_csel)
                card_select_n <= wdata[0];
            // Only a reset clears the kill; no software path exists
            if (wr_csel && !wdata[0] && !kill_src_par)
                kill_cs <= 1'b1;
            if (wr_par)
                par_q <= wdata;
        end
    end
    assign parallel_out = par_q;
    ////////////////////////////////////////////////////////////////////////////
    // Read data, serial port strobes and bus steering
    logic [7:0] io_rdata;
    always_comb
    begin
        io_rdata = `MIO_UNUSED_RD;
        if (hit_uart)
            io_rdata = uart_q;
        else if (hit_spi)
            io_rdata = spi_rx;
        else if (hit_par)
            io_rdata = par_in;
    end
    wire [7:0] mem_rdata = (rd_tgt == mio_pkg::MIO_TGT_ROM) ? rom_q : ram_q;
    wire board_drives = read_act && onboard && (slave || panel_shows_bus);
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_data_in <= 8'h00;
            bus_data_in_oe <= 1'b0;
            bus_wait <= 1'b0;
            rom_addr <= 15'h0000;
            uart_a_sel <= 1'b0;
            uart_b_sel <= 1'b0;
            uart_reg <= 3'h0;
            uart_rd <= 1'b0;
            uart_wr <= 1'b0;
            uart_wdata <= 8'h00;
        end
        else
        begin
            bus_data_in <= io_cycle ? io_rdata : mem_rdata;
            bus_data_in_oe <= board_drives;
            bus_wait <= !fifo_in_ready;
            rom_addr <= a[`MIO_ROM_AW-1:0];
            uart_a_sel <= hit_uart && !hit_uart_b;
            uart_b_sel <= hit_uart_b;
            uart_reg <= ofs[2:0];
            uart_rd <= hit_uart && io_rd;
            uart_wr <= hit_uart && io_wr;
            uart_wdata <= wdata;
        end
    end
    // Slave mode reverses both buffers and holds the local CPU off the bus
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            hold_req <= 1'b0;
            dout_buf_to_bus <= 1'b1;
            din_buf_to_cpu <= 1'b1;
            dout_buf_en <= 1'b0;
            din_buf_en <= 1'b0;
            mem_write <= 1'b0;
            mem_write_oe <= 1'b0;
            run_out <= 1'b0;
            run_oe <= 1'b0;
        end
        else
        begin
            hold_req <= slave;
            dout_buf_to_bus <= !slave;
            din_buf_to_cpu <= !slave;
            dout_buf_en <= slave ? wr_act : 1'b1;
            din_buf_en <= read_act && (slave ? onboard : (ext_mem || !onboard));
            mem_write <= !(wr_n || st_out);
            mem_write_oe <= standalone;
            // Reset only arrives on resetn; run is simply held high
            run_out <= 1'b1;
            run_oe <= standalone;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // SPI: writes queue in the FIFO, bus waits while it is full
    mio_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_spi_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(wr_spi),
        .in_data(wdata),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(spi_pop)
    );
    mio_pkg::mio_spi_state_t spi_state;
    logic [7:0] div_cnt;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [2:0] bit_cnt;
    wire tick = (div_cnt == 8'(HALF - 1));
    assign spi_pop = (spi_state == mio_pkg::MIO_SPI_IDLE) && fifo_out_valid;
    wire last_fall = tick && spi_sclk && (bit_cnt == 3'(`MIO_SPI_BITS - 1));
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            spi_state <= mio_pkg::MIO_SPI_IDLE;
            div_cnt <= 8'h00;
            tx_sh <= 8'h00;
            rx_sh <= 8'h00;
            bit_cnt <= 3'h0;
            spi_sclk <= 1'b0;
            spi_rx <= 8'h00;
        end
        else
        begin
            case (spi_state)
                mio_pkg::MIO_SPI_IDLE:
                begin
                    div_cnt <= 8'h00;
                    spi_sclk <= 1'b0;
                    bit_cnt <= 3'h0;
                    if (spi_pop)
                    begin
                        tx_sh <= fifo_out_data;
                        spi_state <= mio_pkg::MIO_SPI_SHIFT;
                    end
                end
                mio_pkg::MIO_SPI_SHIFT:
                begin
                    div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
                    if (tick)
                    begin
                        spi_sclk <= !spi_sclk;
                        if (!spi_sclk)
                            rx_sh <= {rx_sh[6:0], miso};
                        else
                        begin
                            tx_sh <= {tx_sh[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 3'h1;
                        end
                        if (last_fall)
                        begin
                            spi_rx <= rx_sh;
                            spi_state <= mio_pkg::MIO_SPI_IDLE;
                        end
                    end
                end
                default: spi_state <= mio_pkg::MIO_SPI_IDLE;
            endcase
        end
    end
    assign spi_mosi = tx_sh[7];
    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    chk_csel_kill_sticky: assert property (kill_cs |=> kill_cs)
        else $error("card select kill cleared without reset");
    chk_csel_kill_set: assert property (wr_csel && !wdata[0] && !kill_src_par |=> kill_cs)
        else $error("card select did not kill shadow");
    chk_par_strobe_pulse: assert property (wr_par |=> parallel_strobe ##1 !parallel_strobe)
        else $error("parallel strobe not a single pulse");
    chk_par_out_value: assert property (wr_par |=> parallel_out == $past(wdata))
        else $error("parallel output not loaded");
    chk_par_kill_bit: assert property (kill_src_par && blk_rom && blk_ram
        |-> (rd_tgt == mio_pkg::MIO_TGT_RAM) == parallel_out[0])
        else $error("parallel kill bit not followed");
    chk_io_front_panel: assert property (a[7:0] == 8'hff |-> !io_hit)
        else $error("front panel address decoded on board");
    chk_io_no_base: assert property (io_j == 8'h00 |-> !io_hit)
        else $error("I/O decoded with no base jumper");
    chk_rom_only_read: assert property (blk_rom && !blk_ram |-> rd_tgt == mio_pkg::MIO_TGT_ROM)
        else $error("ROM-only block not reading ROM");
    chk_shadow_killed_ram: assert property (blk_rom && blk_ram && killed
        |-> rd_tgt == mio_pkg::MIO_TGT_RAM)
        else $error("killed shadow block not reading RAM");
    chk_spi_high_time: assert property ($rose(spi_sclk) |-> spi_sclk[*8] ##43 $fell(spi_sclk))
        else $error("SPI clock high time wrong");
    chk_spi_eight_bits: assert property (last_fall |=> spi_state == mio_pkg::MIO_SPI_IDLE
        && spi_rx == $past(rx_sh))
        else $error("SPI transfer did not end after eight bits");
    chk_hold_slave: assert property (slave |=> hold_req && !dout_buf_to_bus)
        else $error("slave mode not holding processor");
    cov_spi_transfer: cover property (spi_pop ##[1:1000] last_fall);
    cov_shadow_kill: cover property (wr_csel && !wdata[0] && !kill_src_par);
    cov_par_write: cover property (wr_par);
    cov_fifo_full: cover property (bus_wait);
endmodule

// [mio_bus_master.sv]
// Bus master model issuing memory and I/O cycles on the bus side
`timescale 1ns/1ps
module mio_bus_master (
    // Clock
    input wire logic clk_sys,
    // Bus drive
    output logic [15:0] bus_addr,
    output logic [7:0] bus_data_out,
    output logic status_mem_read,
    output logic status_io_in,
    output logic status_io_out,
    output logic data_in_strobe,
    output logic write_strobe_n,
    // Board answer
    input wire logic [7:0] bus_data_in,
    input wire logic bus_data_in_oe
);
    initial
    begin
        bus_addr = 16'h0000;
        bus_data_out = 8'h00;
        {status_mem_read, status_io_in, status_io_out, data_in_strobe} = 4'h0;
        write_strobe_n = 1'b1;
    end
    // Kind 0 mem write, 1 io write, 2 mem read, 3 io read
    task automatic cyc(input logic [1:0] kind, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic oe);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_data_out <= d;
        status_io_out <= kind == 2'd1;
        status_mem_read <= kind == 2'd2;
        status_io_in <= kind == 2'd3;
        // Setup margin covers the pin synchronisers
        repeat (6) @(posedge clk_sys);
        write_strobe_n <= kind[1];
        data_in_strobe <= kind[1];
        repeat (10) @(posedge clk_sys);
        q = bus_data_in;
        oe = bus_data_in_oe;
        write_strobe_n <= 1'b1;
        data_in_strobe <= 1'b0;
        repeat (6) @(posedge clk_sys);
        // Released lines must not keep the last value
        bus_addr <= ~a;
        bus_data_out <= ~d;
        {status_mem_read, status_io_in, status_io_out} <= 3'h0;
    endtask
endmodule

// [tb.sv]
// Self-checking bench for the memory and I/O decoder
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] bus_addr;
    logic [14:0] rom_addr;
    logic [7:0] bus_data_out, bus_data_in, rom_data, uart_rdata, parallel_in, parallel_out;
    logic [7:0] ram_block_jumpers, rom_block_jumpers, io_base_jumper, q, s, d [8];
    logic status_mem_read, status_io_in, status_io_out, data_in_strobe, write_strobe_n;
    logic bus_data_in_oe, hold_req, mem_write_oe, run_out, run_oe, spi_mosi, spi_miso;
    logic card_select_n, parallel_strobe, oe, shadow_kill_source_jumper, master_slave_jumper;
    logic machine_type_jumper, external_memory_jumper, standalone_write_jumper;
    logic uart_a_sel, uart_b_sel, uart_rd, spi_sclk, sclk_q;
    logic [2:0] uart_reg;
    logic [7:0] uart_seen;
    int n_sclk = 0;
    int n_mismatch = 0;
    int checked = 0;
    int seed = 32'h5202d6e6;
    int cycles = 0;
    int n_strobe = 0;
    int ns;

    mio_decoder mio_decoder_inst (.clk_sys, .resetn, .bus_addr, .bus_data_out, .status_mem_read,
        .status_io_in, .status_io_out, .data_in_strobe, .write_strobe_n, .bus_data_in,
        .bus_data_in_oe, .bus_wait(), .hold_req, .mem_write(), .mem_write_oe, .run_out, .run_oe,
        .dout_buf_to_bus(), .dout_buf_en(), .din_buf_to_cpu(), .din_buf_en(), .rom_addr,
        .rom_data, .uart_rdata, .uart_a_sel, .uart_b_sel, .uart_reg, .uart_rd,
        .uart_wr(), .uart_wdata(), .spi_sclk, .spi_mosi, .spi_miso, .card_select_n,
        .parallel_in, .parallel_out, .parallel_strobe, .ram_block_jumpers, .rom_block_jumpers,
        .io_base_jumper, .shadow_kill_source_jumper, .master_slave_jumper, .machine_type_jumper,
        .external_memory_jumper, .standalone_write_jumper);
    mio_bus_master mio_bus_master_inst (.clk_sys, .bus_addr, .bus_data_out, .status_mem_read,
        .status_io_in, .status_io_out, .data_in_strobe, .write_strobe_n, .bus_data_in,
        .bus_data_in_oe);

    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] rom_val(input logic [15:0] a);
        return a[7:0] ^ {1'b0, a[14:8]};
    endfunction
    // ROM chip and SD card model; card echoes the inverse of what it hears
    always @(posedge clk_sys)
    begin
        rom_data <= rom_val({1'b0, rom_addr});
        spi_miso <= ~spi_mosi;
        n_strobe <= n_strobe + int'(parallel_strobe === 1'b1);
        sclk_q <= spi_sclk;
        n_sclk <= n_sclk + int'(spi_sclk === 1'b1 && sclk_q === 1'b0);
        if (uart_rd === 1'b1)
            uart_seen <= {3'h0, uart_a_sel, uart_b_sel, uart_reg};
        cycles <= cycles + 1;
        if (cycles == 12000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic io(input logic wr, input logic [7:0] a, input logic [7:0] v);
        mio_bus_master_inst.cyc({!wr, 1'b1}, {a, a}, v, q, oe);
    endtask
    task automatic mem_pass(input logic killed);
        for (int b = 0; b < 8; b++)
        begin
            mio_bus_master_inst.cyc(2'd2, {b[2:0], 13'h0a5}, 8'h00, q, oe);
            chk("mem oe", {7'h0, ram_block_jumpers[b] | rom_block_jumpers[b]}, {7'h0, oe});
            if (oe === 1'b1)
                chk("mem data", (rom_block_jumpers[b] && !(killed && ram_block_jumpers[b])) ?
                    rom_val({b[2:0], 13'h0a5}) : d[b], q);
        end
    endtask
    task automatic do_reset();
        resetn <= 1'b0;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk("csel", 8'h01, {7'h0, card_select_n});
        chk("par out", 8'h00, parallel_out);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {ram_block_jumpers, rom_block_jumpers, io_base_jumper} = {8'hf3, 8'h15, 8'h02};
        {shadow_kill_source_jumper, master_slave_jumper, machine_type_jumper} = 3'b101;
        {external_memory_jumper, standalone_write_jumper} = 2'b00;
        uart_rdata = 8'($random(seed));
        parallel_in = 8'($random(seed));
        do_reset();
        chk("hold", 8'h00, {7'h0, hold_req});
        $display("test reset done");
        s = 8'($random(seed));
        ns = n_strobe;
        io(1'b1, 8'h38, s);
        chk("par out", s, parallel_out);
        chk("strobes", 8'h01, 8'(n_strobe - ns));
        io(1'b0, 8'h38, 8'h00);
        chk("par in", parallel_in, q);
        io(1'b0, 8'h23, 8'h00);
        chk("uart a", uart_rdata, q);
        chk("uart a sel", 8'h13, uart_seen);
        io(1'b0, 8'h2b, 8'h00);
        chk("uart b", uart_rdata, q);
        chk("uart b sel", 8'h0b, uart_seen);
        io(1'b0, 8'h35, 8'h00);
        chk("unused", 8'hff, q);
        io(1'b1, 8'h38, 8'h00);
        $display("test io done");
        for (int b = 0; b < 8; b++)
        begin
            d[b] = 8'($random(seed));
            mio_bus_master_inst.cyc(2'd0, {b[2:0], 13'h0a5}, d[b], q, oe);
        end
        mem_pass(1'b0);
        io(1'b1, 8'h38, 8'h01);
        mem_pass(1'b1);
        io(1'b1, 8'h38, 8'h00);
        mem_pass(1'b0);
        $display("test memory done");
        shadow_kill_source_jumper <= 1'b0;
        io(1'b1, 8'h31, 8'hff);
        mem_pass(1'b0);
        io(1'b1, 8'h31, 8'hfe);
        chk("csel", 8'h00, {7'h0, card_select_n});
        mem_pass(1'b1);
        io(1'b1, 8'h31, 8'h01);
        chk("csel", 8'h01, {7'h0, card_select_n});
        mem_pass(1'b1);
        s = 8'($random(seed));
        ns = n_sclk;
        io(1'b1, 8'h30, s);
        repeat (1000) @(posedge clk_sys);
        chk("sclk rises", 8'h08, 8'(n_sclk - ns));
        io(1'b0, 8'h30, 8'h00);
        chk("spi rx", ~s, q);
        do_reset();
        mem_pass(1'b0);
        $display("test card and spi done");
        for (int i = 0; i < 8; i++)
        begin
            io_base_jumper <= 8'h01 << i;
            io(1'b0, 8'(i * 32 + 24), 8'h00);
            chk("window", parallel_in, q);
        end
        io(1'b0, 8'hff, 8'h00);
        chk("top oe", 8'h00, {7'h0, oe});
        io_base_jumper <= 8'h00;
        io(1'b0, 8'h18, 8'h00);
        chk("none oe", 8'h00, {7'h0, oe});
        {master_slave_jumper, standalone_write_jumper} <= 2'b11;
        repeat (10) @(posedge clk_sys);
        chk("hold", 8'h01, {7'h0, hold_req});
        chk("wr oe", 8'h01, {7'h0, mem_write_oe});
        chk("run", 8'h03, {6'h0, run_out, run_oe});
        $display("test window and modes done");
        end_of_test();
    end
endmodule
